/* File: rtl/cvr_top.sv */
// Read-only cell voltage result registers for channels six to nine over APB
//
// Overview of operation
// - Result sits in bits 15 to 2
// - Full code range spans five volts
// - Disabled skipped channel keeps its stored data
// - Filter select picks averaged or filtered readback
// - Result registers are read-only to software
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module cvr_top #(
  parameter int NUM_CH = cvr_pkg::CVR_NUM_CH,
  parameter int RES_W = cvr_pkg::CVR_RES_W
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cvr_pkg::CVR_ADDR_W-1:0] paddr,
  input wire logic [cvr_pkg::CVR_DATA_W-1:0] pwdata,
  output logic [cvr_pkg::CVR_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Scan engine
  input wire logic scan_update,
  input wire logic [NUM_CH-1:0] scan_skip,
  input wire logic [NUM_CH-1:0][RES_W-1:0] avg_result,
  input wire logic [NUM_CH-1:0][RES_W-1:0] filt_result,
  // Control seen by the scan engine
  output logic [NUM_CH-1:0] channel_measure_enable,
  output logic readback_filter_select
);
  import cvr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] meas_en_r;                 // Measure enables
  logic fsel_r;                                 // Readback filter select
  logic [CVR_DATA_W-1:0] prdata_r;              // Registered read data
  logic [CVR_DATA_W-1:0] prdata_nxt;            // Read data for this setup
  logic pslverr_r;                              // Registered error answer
  logic pslverr_nxt;                            // Error for this setup
  logic setup;                                  // APB setup phase
  logic access;                                 // APB access phase completing
  logic [NUM_CH-1:0][RES_W-1:0] chan_code;      // Selected readback per channel
  logic [NUM_CH-1:0] chan_held;                 // Skipped flags per channel

  // ----------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------
  // True when the byte address hits the word of a register index
  function automatic logic cvr_hit(input logic [CVR_ADDR_W-1:0] a, input logic [CVR_IDX_W-1:0] idx);
    cvr_hit = (a == {2'b00, idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------
  // APB phases
  // ----------------------------------------------------------------
  // Zero wait states while enabled; a frozen block stalls the bus
  assign pready = clk_en;
  assign setup = psel && !penable;
  assign access = psel && penable && clk_en;

  // ----------------------------------------------------------------
  // Channel storage
  // ----------------------------------------------------------------
  // One storage slice per channel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
    cvr_chan #(
      .RES_W(RES_W)
    ) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .scan_update(scan_update),
      .scan_skip(scan_skip[i]),
      .avg_in(avg_result[i]),
      .filt_in(filt_result[i]),
      .channel_measure_enable(meas_en_r[i]),
      .readback_filter_select(fsel_r),
      .code(chan_code[i]),
      .held(chan_held[i])
    );
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Only the control word is writable; result writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_en_r <= NUM_CH'(CVR_EN_RST);
      fsel_r <= CVR_FSEL_RST;
    end else if (access && pwrite && cvr_hit(paddr, CVR_IDX_CTRL)) begin
      meas_en_r <= pwdata[CVR_CTRL_EN_LSB +: NUM_CH];
      fsel_r <= pwdata[CVR_CTRL_FSEL_BIT];
    end
  end

  assign channel_measure_enable = meas_en_r;
  assign readback_filter_select = fsel_r;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Build read word and error flag from the setup address
  always_comb begin
    prdata_nxt = '0;
    pslverr_nxt = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cvr_hit(paddr, CVR_IDX_CELL[i])) begin
        // Code left-justified, low two bits stay zero
        prdata_nxt[CVR_RES_MSB:CVR_RES_LSB] = chan_code[i];
        // Writes here are accepted without effect
        pslverr_nxt = 1'b0;
      end
    end
    if (cvr_hit(paddr, CVR_IDX_CTRL)) begin
      // Control readback
      prdata_nxt[CVR_CTRL_EN_LSB +: NUM_CH] = meas_en_r;
      prdata_nxt[CVR_CTRL_FSEL_BIT] = fsel_r;
      pslverr_nxt = 1'b0;
    end
    if (cvr_hit(paddr, CVR_IDX_STAT)) begin
      // Skipped flags of the latest scan
      prdata_nxt[CVR_STAT_SKIP_LSB +: NUM_CH] = chan_held;
      pslverr_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data and error registers
  // ----------------------------------------------------------------
  // Captured in the setup cycle, presented through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (clk_en && setup) begin
      prdata_r <= pwrite ? '0 : prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Result reads carry the selected code in bits 15 to 2
  field_place_a: assert property (
    (clk_en && setup && !pwrite && cvr_hit(paddr, CVR_IDX_CELL6))
    |=> prdata[CVR_RES_MSB:CVR_RES_LSB] == $past(chan_code[0]))
    else $error("cell six code not at bits 15 to 2");

  // A full-span code reads back as all ones in the field
  full_span_a: assert property (
    (clk_en && scan_update && meas_en_r[1] && avg_result[1] == CVR_CODE_MAX && !fsel_r && !(access && pwrite))
    |=> chan_code[1] == CVR_CODE_MAX)
    else $error("full span code not stored");

  // Disabled skipped channel keeps its value for the next cycle
  skip_hold_a: assert property (
    (clk_en && scan_update && !meas_en_r[1] && scan_skip[1] && !(access && pwrite))
    |=> $stable(chan_code[1]) && chan_held[1])
    else $error("skipped channel data changed");

  // Measured channel loads the averaged input
  meas_load_a: assert property (
    (clk_en && scan_update && meas_en_r[0] && !fsel_r && !(access && pwrite))
    |=> chan_code[0] == $past(avg_result[0]))
    else $error("measured channel not loaded");

  // With filter select set after a measuring scan, readback shows the filtered value
  sel_filt_a: assert property (
    (clk_en && scan_update && meas_en_r[3]) ##1 (fsel_r && !(clk_en && scan_update))
    |-> chan_code[3] == $past(filt_result[3]))
    else $error("filtered value not on readback");

  // Software write to a result register leaves it unchanged
  ro_write_a: assert property (
    (access && pwrite && cvr_hit(paddr, CVR_IDX_CELL9) && !scan_update)
    |=> $stable(chan_code[3]) && !pslverr)
    else $error("result register altered by write");

  // Low two bits and upper half read zero on result reads
  low_zero_a: assert property (
    (clk_en && setup && !pwrite && cvr_hit(paddr, CVR_IDX_CELL8))
    |=> prdata[CVR_RES_LSB-1:0] == '0 && prdata[CVR_DATA_W-1:CVR_RES_MSB+1] == '0)
    else $error("unused result bits not zero");

  // Unmapped address answers with an error
  unmapped_a: assert property (
    (clk_en && setup && !(cvr_hit(paddr, CVR_IDX_CTRL) || cvr_hit(paddr, CVR_IDX_STAT) ||
      (paddr[CVR_ADDR_W-1:2] >= {2'b00, CVR_IDX_CELL6} && paddr[CVR_ADDR_W-1:2] <= {2'b00, CVR_IDX_CELL9}
       && paddr[1:0] == 2'b00)))
    |=> pslverr)
    else $error("unmapped access without error");

  // Main scenarios
  rd_cell_c: cover property (clk_en && access && !pwrite && cvr_hit(paddr, CVR_IDX_CELL7));
  skip_c: cover property (clk_en && scan_update && !meas_en_r[1] && scan_skip[1]);
  filt_rd_c: cover property (fsel_r && access && !pwrite && cvr_hit(paddr, CVR_IDX_CELL6));
  err_c: cover property (access && pslverr);

endmodule // cvr_top

/* File: shared/cvr_pkg.sv */
// Shared constants for the cell voltage result bank, channels six to nine
package cvr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CVR_NUM_CH = 4;           // Channels six to nine
  localparam int CVR_RES_W = 14;           // Conversion result width
  localparam int CVR_DATA_W = 32;          // APB data width
  localparam int CVR_ADDR_W = 12;          // APB address width
  localparam int CVR_IDX_W = 8;            // Register index width

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] CVR_IDX_CELL6 = 8'h4c;   // Cell six result
  localparam logic [7:0] CVR_IDX_CELL7 = 8'h4d;   // Cell seven result
  localparam logic [7:0] CVR_IDX_CELL8 = 8'h4e;   // Cell eight result
  localparam logic [7:0] CVR_IDX_CELL9 = 8'h4f;   // Cell nine result
  localparam logic [7:0] CVR_IDX_CTRL = 8'h60;    // Measure enables and filter select
  localparam logic [7:0] CVR_IDX_STAT = 8'h61;    // Skipped-in-last-scan flags
  localparam logic [7:0] CVR_IDX_CELL [CVR_NUM_CH] = '{CVR_IDX_CELL6, CVR_IDX_CELL7,
                                                      CVR_IDX_CELL8, CVR_IDX_CELL9};

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CVR_RES_MSB = 15;         // Result MSB position
  localparam int CVR_RES_LSB = 2;          // Result LSB position
  localparam int CVR_CTRL_EN_LSB = 0;      // Measure enables, one bit per channel
  localparam int CVR_CTRL_FSEL_BIT = 4;    // Readback filter select
  localparam int CVR_STAT_SKIP_LSB = 0;    // Skipped flags, one per channel

  // ----------------------------------------------------------------
  // Reset values and scaling
  // ----------------------------------------------------------------
  localparam logic [3:0] CVR_EN_RST = 4'hf;        // All channels measured
  localparam logic CVR_FSEL_RST = 1'b0;            // Averaged value on readback
  localparam logic [13:0] CVR_CODE_RST = 14'h0000; // Stored result at reset
  localparam logic [13:0] CVR_CODE_MAX = 14'h3fff; // Code for the full span
  localparam int CVR_FULL_SCALE_MV = 5000;         // Span of the full code range

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [CVR_RES_W-1:0] cvr_code_t;        // One conversion code

endpackage

/* File: rtl/cvr_chan.sv */
// One channel of stored averaged and filtered results with readback select
`timescale 1ns/1ps
module cvr_chan #(
  parameter int RES_W = 14
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Scan engine side
  input wire logic scan_update,
  input wire logic scan_skip,
  input wire logic [RES_W-1:0] avg_in,
  input wire logic [RES_W-1:0] filt_in,
  // Control
  input wire logic channel_measure_enable,
  input wire logic readback_filter_select,
  // Readback
  output logic [RES_W-1:0] code,
  output logic held
);
  import cvr_pkg::*;

  logic [RES_W-1:0] avg_r;   // Averaged result
  logic [RES_W-1:0] filt_r;  // Filtered result
  logic held_r;              // Channel skipped in the latest scan

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Skipped and disabled channel keeps its data; otherwise both values load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_r <= RES_W'(CVR_CODE_RST);
      filt_r <= RES_W'(CVR_CODE_RST);
      held_r <= 1'b0;
    end else if (clk_en && scan_update) begin
      if (!channel_measure_enable && scan_skip) begin
        // Only the skipped flag is set; stored results keep their values
        held_r <= 1'b1;
      end else begin
        // Code taken as-is: full range spans the five volt input
        avg_r <= avg_in;
        filt_r <= filt_in;
        held_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  // Filter select picks filtered or averaged value
  assign code = readback_filter_select ? filt_r : avg_r;
  assign held = held_r;

endmodule // cvr_chan

/* File: test/tb_cvr_top.sv */
// Self-checking bench for the cell voltage result bank, channels six to nine
`timescale 1ns/1ps
module tb_cvr_top;
  import cvr_pkg::*;
  // ----------------------------------------------------------------
  // Signals and expected state
  // ----------------------------------------------------------------
  logic pclk, presetn, clk_en; // Clock, reset, enable
  logic psel, penable, pwrite; // APB request
  logic [CVR_ADDR_W-1:0] paddr;
  logic [CVR_DATA_W-1:0] pwdata, prdata;
  logic pready, pslverr;
  logic scan_update; // Scan engine side
  logic [CVR_NUM_CH-1:0] scan_skip, channel_measure_enable;
  logic [CVR_NUM_CH-1:0][CVR_RES_W-1:0] avg_result, filt_result;
  logic readback_filter_select;
  int errors, comparisons; // Verdict counters
  cvr_code_t avg_e [CVR_NUM_CH]; // Expected stored averaged codes
  cvr_code_t filt_e [CVR_NUM_CH]; // Expected stored filtered codes
  cvr_code_t nav [CVR_NUM_CH]; // Next scan averaged codes
  cvr_code_t nfl [CVR_NUM_CH]; // Next scan filtered codes
  logic [3:0] en_e; // Expected measure enables
  logic fsel_e; // Expected filter select
  logic [31:0] rd; // Last read data
  logic err; // Last error response
  localparam logic [11:0] CTRL_ADDR = {2'b00, CVR_IDX_CTRL, 2'b00};
  localparam logic [11:0] STAT_ADDR = {2'b00, CVR_IDX_STAT, 2'b00};

  cvr_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_update(scan_update), .scan_skip(scan_skip), .avg_result(avg_result), .filt_result(filt_result),
    .channel_measure_enable(channel_measure_enable), .readback_filter_select(readback_filter_select));

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Cuts a hang short well beyond the roughly 150 cycles the tests need
  initial begin
    repeat (4000) @(posedge pclk);
    errors++;
    wrap_up();
  end

  task automatic wrap_up();
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] cell_addr(input int i);
    return {2'b00, CVR_IDX_CELL[i], 2'b00};
  endfunction

  // Result left-justified, two low bits zero, selected by filter select
  function automatic logic [31:0] cell_exp(input int i);
    return {16'h0000, (fsel_e ? filt_e[i] : avg_e[i]), 2'b00};
  endfunction

  task automatic check_all();
    for (int i = 0; i < CVR_NUM_CH; i++) begin
      apb(1'b0, cell_addr(i), 32'h0);
      check(rd, cell_exp(i));
      check({31'h0, err}, 32'h0);
    end
  endtask

  task automatic set_ctrl(input logic [3:0] en, input logic fsel);
    apb(1'b1, CTRL_ADDR, {27'h0, fsel, en});
    en_e = en;
    fsel_e = fsel;
    #1;
    check({27'h0, readback_filter_select, channel_measure_enable}, {27'h0, fsel, en});
  endtask

  // One scan pulse; model loads unless disabled and skipped, or frozen
  task automatic do_scan(input logic [3:0] skip);
    @(posedge pclk);
    scan_update <= 1'b1;
    scan_skip <= skip;
    for (int i = 0; i < CVR_NUM_CH; i++) begin
      avg_result[i] <= nav[i];
      filt_result[i] <= nfl[i];
      if (clk_en && (en_e[i] || !skip[i])) begin
        avg_e[i] = nav[i];
        filt_e[i] = nfl[i];
      end
    end
    @(posedge pclk);
    scan_update <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    scan_update = 1'b0;
    scan_skip = '0;
    avg_result = '0;
    filt_result = '0;
    errors = 0;
    comparisons = 0;
    en_e = CVR_EN_RST;
    fsel_e = CVR_FSEL_RST;
    avg_e = '{default: CVR_CODE_RST};
    filt_e = '{default: CVR_CODE_RST};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset contents of results and control
    check_all();
    apb(1'b0, CTRL_ADDR, 32'h0);
    check(rd, 32'h0000000f);
    // Full-scale and boundary codes, averaged then filtered readback
    nav = '{14'h0001, 14'h3fff, 14'h2aaa, 14'h1555};
    nfl = '{14'h0123, 14'h3ffe, 14'h0000, 14'h2001};
    do_scan(4'h0);
    check_all();
    set_ctrl(4'hf, 1'b1);
    check_all();
    // Software writes to result registers leave them untouched
    for (int i = 0; i < CVR_NUM_CH; i++) begin
      apb(1'b1, cell_addr(i), 32'hffffffff);
      check({31'h0, err}, 32'h0);
    end
    check_all();
    // Seven disabled and skipped keeps data; nine disabled but measured loads
    set_ctrl(4'b0101, 1'b0);
    nav = '{14'h0fff, 14'h3000, 14'h0005, 14'h3ffc};
    nfl = '{14'h1111, 14'h2222, 14'h3333, 14'h0444};
    do_scan(4'b0111);
    check_all();
    // Only cell seven is flagged as skipped
    apb(1'b0, STAT_ADDR, 32'h0);
    check(rd, 32'h00000002);
    set_ctrl(4'b0101, 1'b1);
    check_all();
    // A scan pulse while clock enable is low changes nothing
    @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    // A frozen block holds the bus answer back
    check({31'h0, pready}, 32'h0);
    nav = '{14'h0000, 14'h0000, 14'h0000, 14'h0000};
    do_scan(4'h0);
    clk_en <= 1'b1;
    check_all();
    // Enabled channels load even when skipped; filtered readback selected
    set_ctrl(4'hf, 1'b1);
    nfl = '{14'h0abc, 14'h1def, 14'h2468, 14'h3579};
    do_scan(4'hf);
    check_all();
    // A loading scan clears every skipped flag
    apb(1'b0, STAT_ADDR, 32'h0);
    check(rd, 32'h00000000);
    // Unmapped and misaligned addresses answer with an error and zero data
    apb(1'b0, 12'h000, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    apb(1'b0, 12'h131, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    wrap_up();
  end
endmodule // tb_cvr_top
